// *** common/alu_slice_pkg.sv ***
// Shared constants and types for the decrement, xor and decimal-adjust slice
package alu_slice_pkg;
  // ===========================================
  // Opcodes
  localparam logic [7:0] OP_BCD_ADJ = 8'h19;
  localparam logic [7:0] OP_DEC_A = 8'h4a;
  localparam logic [7:0] OP_DEC_B = 8'h5a;
  localparam logic [7:0] OP_DEC_EXT = 8'h7a;
  localparam logic [7:0] OP_DEC_IDX = 8'h6a;
  localparam logic [7:0] OP_PREFIX_Y = 8'h18;
  localparam logic [7:0] OP_DEC_STACK = 8'h34;
  localparam logic [7:0] OP_DEC_XY = 8'h09;
  localparam logic [7:0] OP_XOR_A_IMM = 8'h88;
  localparam logic [7:0] OP_XOR_A_DIR = 8'h98;
  localparam logic [7:0] OP_XOR_A_EXT = 8'hb8;
  localparam logic [7:0] OP_XOR_A_IDX = 8'ha8;
  localparam logic [7:0] OP_XOR_B_IMM = 8'hc8;
  localparam logic [7:0] OP_XOR_B_DIR = 8'hd8;
  localparam logic [7:0] OP_XOR_B_EXT = 8'hf8;
  localparam logic [7:0] OP_XOR_B_IDX = 8'he8;
  // ===========================================
  // Condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_H = 5;
  // ===========================================
  // Decimal adjust corrections, decrement overflow value and bus constants
  localparam logic [7:0] CORR_LO = 8'h06;
  localparam logic [7:0] CORR_HI = 8'h60;
  localparam logic [7:0] MIN_NEG = 8'h80;
  localparam logic [15:0] IDLE_ADDR = 16'hffff;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  // ===========================================
  // Register port indices
  localparam logic [3:0] REG_ACC_A = 4'h0;
  localparam logic [3:0] REG_ACC_B = 4'h1;
  localparam logic [3:0] REG_INDEX_X = 4'h2;
  localparam logic [3:0] REG_INDEX_Y = 4'h3;
  localparam logic [3:0] REG_STACK = 4'h4;
  localparam logic [3:0] REG_FLAGS = 4'h5;
  localparam logic [3:0] REG_PC = 4'h6;
  localparam logic [3:0] REG_CTRL = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_RUN = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BAD_OP = 1;
  // ===========================================
  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ===========================================
  // Types
  typedef enum logic [1:0] {ALU_BCD = 2'h0, ALU_DEC = 2'h1, ALU_XOR = 2'h2, ALU_PASS = 2'h3} alu_op_t;
  typedef enum logic [1:0] {MODE_IMM = 2'h0, MODE_DIR = 2'h1, MODE_IDX = 2'h2, MODE_EXT = 2'h3} mode_t;
  typedef enum logic [3:0] {
    S_FETCH = 4'b0000, S_PAGE = 4'b0001, S_ARG1 = 4'b0011, S_ARG2 = 4'b0010,
    S_DUMMY = 4'b0110, S_READ = 4'b0111, S_IDLE = 4'b0101, S_WRITE = 4'b0100,
    S_INH = 4'b1100, S_SPREAD = 4'b1101, S_HALT = 4'b1111
  } state_t;
endpackage

// *** hw/alu8.sv ***
// Eight-bit unit: decimal adjust, decrement and exclusive-or with flags
`timescale 1ns/1ps
module alu8 (
  input wire alu_slice_pkg::alu_op_t op, // Operation
  input wire logic [7:0] a, // Accumulator or memory operand
  input wire logic [7:0] b, // Memory operand for xor
  input wire logic [7:0] ccr_in, // Flags before
  output logic [7:0] res, // Result
  output logic [7:0] ccr_out // Flags after
);
  logic lo_adj;
  logic hi_adj;
  logic [7:0] corr;

  always_comb begin
    lo_adj = ccr_in[alu_slice_pkg::CC_H] || (a[3:0] > 4'h9);
    hi_adj = ccr_in[alu_slice_pkg::CC_C] || (a[7:4] > 4'h9) || ((a[7:4] > 4'h8) && (a[3:0] > 4'h9));
    corr = (hi_adj ? alu_slice_pkg::CORR_HI : 8'h00) | (lo_adj ? alu_slice_pkg::CORR_LO : 8'h00);
    ccr_out = ccr_in;
    res = a;
    case (op)
      alu_slice_pkg::ALU_BCD: begin
        res = a + corr;
        ccr_out[alu_slice_pkg::CC_C] = hi_adj;
      end
      alu_slice_pkg::ALU_DEC: begin
        res = a - 8'h01;
        ccr_out[alu_slice_pkg::CC_V] = (a == alu_slice_pkg::MIN_NEG);
      end
      alu_slice_pkg::ALU_XOR: begin
        res = a ^ b;
        ccr_out[alu_slice_pkg::CC_V] = 1'b0;
      end
      default: res = a;
    endcase
    if (op != alu_slice_pkg::ALU_PASS) begin
      ccr_out[alu_slice_pkg::CC_N] = res[7];
      ccr_out[alu_slice_pkg::CC_Z] = (res == 8'h00);
    end
  end
endmodule // alu8

// *** hw/dec16.sv ***
// Sixteen-bit decrement with zero detect
`timescale 1ns/1ps
module dec16 (
  input wire logic [15:0] value, // Operand
  output logic [15:0] result, // Operand minus one
  output logic zero // Result is zero
);
  assign result = value - 16'h0001;
  assign zero = (result == 16'h0000);
endmodule // dec16

// *** hw/alu_slice_top.sv ***
// Sequencer and register set for the decrement, xor and decimal-adjust slice
`timescale 1ns/1ps
module alu_slice_top (
  input wire logic CLOCK, // 50 MHz clock
  input wire logic RSTN, // Asynchronous reset, active low
  output logic [15:0] ADDR, // Bus address
  output logic RW, // High read, low write
  output logic [7:0] WDATA, // Write data
  input wire logic [7:0] RDATA, // Read data, sampled at end of cycle
  input wire logic [3:0] REG_ADDR, // Register index
  input wire logic [15:0] REG_WDATA, // Register write data
  input wire logic REG_WR, // Register write strobe
  input wire logic REG_RD, // Register read strobe
  output logic [15:0] REG_RDATA // Register read data, one cycle later
);
  alu_slice_pkg::state_t state;
  alu_slice_pkg::state_t next_state;
  alu_slice_pkg::alu_op_t alu_op;
  logic [7:0] acc_a;
  logic [7:0] acc_b;
  logic [7:0] condition_code_reg;
  logic [15:0] index_x;
  logic [15:0] index_y;
  logic [15:0] stack;
  logic [15:0] pc;
  logic run;
  logic bad_op;
  logic [7:0] op;
  logic pre;
  logic [7:0] hi;
  logic [15:0] eff;
  logic [7:0] tmp;
  logic [15:0] next_addr;
  logic next_rw;
  logic [7:0] next_wdata;
  logic [7:0] next_op;
  logic next_pre;
  logic [7:0] next_hi;
  logic [15:0] next_eff;
  logic [7:0] next_tmp;
  logic [15:0] pc_n;
  logic pc_step;
  logic entry;
  logic bad;
  logic [7:0] code;
  logic sel_b;
  logic [7:0] alu_a;
  logic [7:0] alu_res;
  logic [7:0] alu_ccr;
  logic [15:0] d16_in;
  logic [15:0] d16_res;
  logic d16_zero;
  logic acc_we;
  logic ccr_we;
  logic idx_exec;
  logic sp_exec;

  // ===========================================
  // Decode helpers
  function automatic logic is_legal(input logic [7:0] c, input logic p);
    if (p) begin
      is_legal = (c == alu_slice_pkg::OP_DEC_XY) || (c == alu_slice_pkg::OP_DEC_IDX) ||
                 (c == alu_slice_pkg::OP_XOR_A_IDX) || (c == alu_slice_pkg::OP_XOR_B_IDX);
    end else begin
      case (c)
        alu_slice_pkg::OP_BCD_ADJ, alu_slice_pkg::OP_DEC_A, alu_slice_pkg::OP_DEC_B,
        alu_slice_pkg::OP_DEC_EXT, alu_slice_pkg::OP_DEC_IDX, alu_slice_pkg::OP_DEC_STACK,
        alu_slice_pkg::OP_DEC_XY, alu_slice_pkg::OP_XOR_A_IMM, alu_slice_pkg::OP_XOR_A_DIR,
        alu_slice_pkg::OP_XOR_A_EXT, alu_slice_pkg::OP_XOR_A_IDX, alu_slice_pkg::OP_XOR_B_IMM,
        alu_slice_pkg::OP_XOR_B_DIR, alu_slice_pkg::OP_XOR_B_EXT, alu_slice_pkg::OP_XOR_B_IDX: begin
          is_legal = 1'b1;
        end
        default: is_legal = 1'b0;
      endcase
    end
  endfunction

  function automatic logic is_inherent(input logic [7:0] c);
    is_inherent = (c == alu_slice_pkg::OP_BCD_ADJ) || (c == alu_slice_pkg::OP_DEC_A) ||
                  (c == alu_slice_pkg::OP_DEC_B) || (c == alu_slice_pkg::OP_DEC_STACK) ||
                  (c == alu_slice_pkg::OP_DEC_XY);
  endfunction

  function automatic logic is_dec_mem(input logic [7:0] c);
    is_dec_mem = (c == alu_slice_pkg::OP_DEC_EXT) || (c == alu_slice_pkg::OP_DEC_IDX);
  endfunction

  function automatic alu_slice_pkg::mode_t addr_mode(input logic [7:0] c);
    addr_mode = alu_slice_pkg::mode_t'(c[5:4]);
  endfunction

  // ===========================================
  // Datapath
  assign code = RDATA;
  assign sel_b = (op[3:0] == 4'ha) ? op[4] : op[6];
  assign alu_a = (state == alu_slice_pkg::S_IDLE) ? tmp : (sel_b ? acc_b : acc_a);
  assign alu_op = ((state == alu_slice_pkg::S_IDLE) || (op[3:0] == 4'ha)) ? alu_slice_pkg::ALU_DEC :
                  ((op == alu_slice_pkg::OP_BCD_ADJ) ? alu_slice_pkg::ALU_BCD : alu_slice_pkg::ALU_XOR);
  assign d16_in = (state == alu_slice_pkg::S_SPREAD) ? stack : (pre ? index_y : index_x);
  assign pc_step = (state == alu_slice_pkg::S_FETCH) || (state == alu_slice_pkg::S_PAGE) ||
                   (state == alu_slice_pkg::S_ARG1) || (state == alu_slice_pkg::S_ARG2);
  assign pc_n = pc_step ? pc + 16'h0001 : pc;
  assign acc_we = ((state == alu_slice_pkg::S_INH) && (op == alu_slice_pkg::OP_BCD_ADJ ||
                   op == alu_slice_pkg::OP_DEC_A || op == alu_slice_pkg::OP_DEC_B)) ||
                  ((state == alu_slice_pkg::S_ARG1) && (addr_mode(op) == alu_slice_pkg::MODE_IMM)) ||
                  ((state == alu_slice_pkg::S_READ) && !is_dec_mem(op));
  assign idx_exec = (state == alu_slice_pkg::S_DUMMY) && (op == alu_slice_pkg::OP_DEC_XY);
  assign sp_exec = (state == alu_slice_pkg::S_SPREAD);
  assign ccr_we = acc_we || (state == alu_slice_pkg::S_IDLE);

  alu8 u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(RDATA),
    .ccr_in(condition_code_reg),
    .res(alu_res),
    .ccr_out(alu_ccr)
  );

  dec16 u_dec16 (
    .value(d16_in),
    .result(d16_res),
    .zero(d16_zero)
  );

  // ===========================================
  // Bus sequencer, next values
  always_comb begin
    next_state = state;
    next_addr = alu_slice_pkg::IDLE_ADDR;
    next_rw = 1'b1;
    next_wdata = WDATA;
    next_op = op;
    next_pre = pre;
    next_hi = hi;
    next_eff = eff;
    next_tmp = tmp;
    entry = 1'b0;
    bad = 1'b0;
    case (state)
      alu_slice_pkg::S_HALT: begin
        if (run) begin
          next_state = alu_slice_pkg::S_FETCH;
          next_addr = pc;
        end
      end
      alu_slice_pkg::S_FETCH: begin
        next_pre = 1'b0;
        if (code == alu_slice_pkg::OP_PREFIX_Y) begin
          next_pre = 1'b1;
          next_state = alu_slice_pkg::S_PAGE;
          next_addr = pc_n;
        end else begin
          entry = 1'b1;
        end
      end
      alu_slice_pkg::S_PAGE: entry = 1'b1;
      alu_slice_pkg::S_INH: begin
        if (op == alu_slice_pkg::OP_DEC_STACK) begin
          next_state = alu_slice_pkg::S_SPREAD;
          next_addr = stack;
        end else if (op == alu_slice_pkg::OP_DEC_XY) begin
          next_state = alu_slice_pkg::S_DUMMY;
        end else begin
          next_state = alu_slice_pkg::S_FETCH;
        end
      end
      alu_slice_pkg::S_ARG1: begin
        case (addr_mode(op))
          alu_slice_pkg::MODE_IMM: next_state = alu_slice_pkg::S_FETCH;
          alu_slice_pkg::MODE_DIR: begin
            next_state = alu_slice_pkg::S_READ;
            next_eff = {alu_slice_pkg::PAGE_ZERO, RDATA};
            next_addr = next_eff;
          end
          alu_slice_pkg::MODE_EXT: begin
            next_state = alu_slice_pkg::S_ARG2;
            next_hi = RDATA;
            next_addr = pc_n;
          end
          default: begin
            next_state = alu_slice_pkg::S_DUMMY;
            next_eff = (pre ? index_y : index_x) + {8'h00, RDATA};
          end
        endcase
      end
      alu_slice_pkg::S_ARG2: begin
        next_state = alu_slice_pkg::S_READ;
        next_eff = {hi, RDATA};
        next_addr = next_eff;
      end
      alu_slice_pkg::S_DUMMY: begin
        if (op == alu_slice_pkg::OP_DEC_XY) begin
          next_state = alu_slice_pkg::S_FETCH;
        end else begin
          next_state = alu_slice_pkg::S_READ;
          next_addr = eff;
        end
      end
      alu_slice_pkg::S_READ: begin
        if (is_dec_mem(op)) begin
          next_state = alu_slice_pkg::S_IDLE;
          next_tmp = RDATA;
        end else begin
          next_state = alu_slice_pkg::S_FETCH;
        end
      end
      alu_slice_pkg::S_IDLE: begin
        next_state = alu_slice_pkg::S_WRITE;
        next_addr = eff;
        next_rw = 1'b0;
        next_wdata = alu_res;
      end
      alu_slice_pkg::S_SPREAD, alu_slice_pkg::S_WRITE: next_state = alu_slice_pkg::S_FETCH;
      default: next_state = alu_slice_pkg::S_HALT;
    endcase
    if (entry) begin
      next_op = code;
      if (!is_legal(code, state == alu_slice_pkg::S_PAGE)) begin
        bad = 1'b1;
        next_state = alu_slice_pkg::S_HALT;
      end else if (is_inherent(code)) begin
        next_state = alu_slice_pkg::S_INH;
        next_addr = pc_n;
      end else begin
        next_state = alu_slice_pkg::S_ARG1;
        next_addr = pc_n;
      end
    end
    if (next_state == alu_slice_pkg::S_FETCH) begin
      next_state = run ? alu_slice_pkg::S_FETCH : alu_slice_pkg::S_HALT;
      next_addr = run ? pc_n : alu_slice_pkg::IDLE_ADDR;
    end
  end

  // ===========================================
  // Bus sequencer, state
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= alu_slice_pkg::S_HALT;
      ADDR <= alu_slice_pkg::IDLE_ADDR;
      RW <= 1'b1;
      WDATA <= alu_slice_pkg::ACC_RESET;
      op <= alu_slice_pkg::ACC_RESET;
      pre <= 1'b0;
      hi <= alu_slice_pkg::ACC_RESET;
      eff <= alu_slice_pkg::WORD_RESET;
      tmp <= alu_slice_pkg::ACC_RESET;
    end else begin
      state <= next_state;
      ADDR <= next_addr;
      RW <= next_rw;
      WDATA <= next_wdata;
      op <= next_op;
      pre <= next_pre;
      hi <= next_hi;
      eff <= next_eff;
      tmp <= next_tmp;
    end
  end

  // ===========================================
  // Program counter
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pc <= alu_slice_pkg::WORD_RESET;
    end else if (REG_WR && REG_ADDR == alu_slice_pkg::REG_PC && state == alu_slice_pkg::S_HALT) begin
      pc <= REG_WDATA;
    end else begin
      pc <= pc_n;
    end
  end

  // ===========================================
  // Programmer registers; execution wins over a software write
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      acc_a <= alu_slice_pkg::ACC_RESET;
      acc_b <= alu_slice_pkg::ACC_RESET;
      condition_code_reg <= alu_slice_pkg::CCR_RESET;
      index_x <= alu_slice_pkg::WORD_RESET;
      index_y <= alu_slice_pkg::WORD_RESET;
      stack <= alu_slice_pkg::WORD_RESET;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          alu_slice_pkg::REG_ACC_A: acc_a <= REG_WDATA[7:0];
          alu_slice_pkg::REG_ACC_B: acc_b <= REG_WDATA[7:0];
          alu_slice_pkg::REG_FLAGS: condition_code_reg <= REG_WDATA[7:0];
          alu_slice_pkg::REG_INDEX_X: index_x <= REG_WDATA;
          alu_slice_pkg::REG_INDEX_Y: index_y <= REG_WDATA;
          alu_slice_pkg::REG_STACK: stack <= REG_WDATA;
          default: ;
        endcase
      end
      if (acc_we && sel_b) begin
        acc_b <= alu_res;
      end else if (acc_we) begin
        acc_a <= alu_res;
      end
      if (ccr_we) begin
        condition_code_reg <= alu_ccr;
      end else if (idx_exec) begin
        condition_code_reg <= {condition_code_reg[7:3], d16_zero, condition_code_reg[1:0]};
      end
      if (idx_exec && pre) begin
        index_y <= d16_res;
      end else if (idx_exec) begin
        index_x <= d16_res;
      end
      if (sp_exec) begin
        stack <= d16_res;
      end
    end
  end

  // ===========================================
  // Run control and bad opcode flag
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      run <= 1'b0;
      bad_op <= 1'b0;
    end else begin
      if (bad) begin
        run <= 1'b0;
      end else if (REG_WR && REG_ADDR == alu_slice_pkg::REG_CTRL) begin
        run <= REG_WDATA[alu_slice_pkg::CTRL_RUN];
      end
      if (bad) begin
        bad_op <= 1'b1;
      end else if (REG_WR && REG_ADDR == alu_slice_pkg::REG_STATUS && REG_WDATA[alu_slice_pkg::STAT_BAD_OP]) begin
        bad_op <= 1'b0;
      end
    end
  end

  // ===========================================
  // Register read port
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= alu_slice_pkg::WORD_RESET;
    end else if (!REG_RD) begin
      REG_RDATA <= alu_slice_pkg::WORD_RESET;
    end else begin
      case (REG_ADDR)
        alu_slice_pkg::REG_ACC_A: REG_RDATA <= {8'h00, acc_a};
        alu_slice_pkg::REG_ACC_B: REG_RDATA <= {8'h00, acc_b};
        alu_slice_pkg::REG_FLAGS: REG_RDATA <= {8'h00, condition_code_reg};
        alu_slice_pkg::REG_INDEX_X: REG_RDATA <= index_x;
        alu_slice_pkg::REG_INDEX_Y: REG_RDATA <= index_y;
        alu_slice_pkg::REG_STACK: REG_RDATA <= stack;
        alu_slice_pkg::REG_PC: REG_RDATA <= pc;
        alu_slice_pkg::REG_CTRL: REG_RDATA <= {15'h0000, run};
        alu_slice_pkg::REG_STATUS: REG_RDATA <= {14'h0000, bad_op, state != alu_slice_pkg::S_HALT};
        default: REG_RDATA <= alu_slice_pkg::WORD_RESET;
      endcase
    end
  end

  // ===========================================
  // Assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence s_bcd_tail;
    (state == alu_slice_pkg::S_INH && RW && ADDR == $past(ADDR) + 16'h0001)
      ##1 (state == alu_slice_pkg::S_FETCH || state == alu_slice_pkg::S_HALT);
  endsequence
  property p_bcd_two;
    (state == alu_slice_pkg::S_FETCH && RDATA == alu_slice_pkg::OP_BCD_ADJ) |=> s_bcd_tail;
  endproperty
  a_bcd_two: assert property (p_bcd_two) else $error("adjust not two read cycles");

  property p_bcd_66;
    (state == alu_slice_pkg::S_INH && op == alu_slice_pkg::OP_BCD_ADJ && !condition_code_reg[alu_slice_pkg::CC_C] &&
     !condition_code_reg[alu_slice_pkg::CC_H] && acc_a[7:4] > 4'h8 && acc_a[3:0] > 4'h9)
      |=> (acc_a == $past(acc_a) + (alu_slice_pkg::CORR_HI | alu_slice_pkg::CORR_LO) && condition_code_reg[alu_slice_pkg::CC_C]);
  endproperty
  a_bcd_66: assert property (p_bcd_66) else $error("adjust did not add 66");

  property p_dec_carry;
    (ccr_we && alu_op == alu_slice_pkg::ALU_DEC) |=> condition_code_reg[alu_slice_pkg::CC_C] == $past(condition_code_reg[alu_slice_pkg::CC_C]);
  endproperty
  a_dec_carry: assert property (p_dec_carry) else $error("decrement changed carry");

  property p_dec_ovf;
    (ccr_we && alu_op == alu_slice_pkg::ALU_DEC) |=> condition_code_reg[alu_slice_pkg::CC_V] == ($past(alu_a) == alu_slice_pkg::MIN_NEG);
  endproperty
  a_dec_ovf: assert property (p_dec_ovf) else $error("decrement overflow wrong");

  property p_dec_nz;
    (state == alu_slice_pkg::S_INH && op == alu_slice_pkg::OP_DEC_A)
      |=> (condition_code_reg[alu_slice_pkg::CC_N] == acc_a[7] && condition_code_reg[alu_slice_pkg::CC_Z] == (acc_a == 8'h00));
  endproperty
  a_dec_nz: assert property (p_dec_nz) else $error("decrement N or Z wrong");

  sequence s_rmw_tail;
    (state == alu_slice_pkg::S_IDLE && ADDR == alu_slice_pkg::IDLE_ADDR && RW) ##1 (state == alu_slice_pkg::S_WRITE && !RW);
  endsequence
  property p_rmw;
    (state == alu_slice_pkg::S_READ && is_dec_mem(op))
      |=> s_rmw_tail ##0 (ADDR == $past(ADDR, 2) && WDATA == $past(RDATA, 2) - 8'h01);
  endproperty
  a_rmw: assert property (p_rmw) else $error("memory decrement sequence wrong");

  property p_sp;
    (state == alu_slice_pkg::S_SPREAD && !REG_WR) |=> (stack == $past(stack) - 16'h0001 && condition_code_reg == $past(condition_code_reg));
  endproperty
  a_sp: assert property (p_sp) else $error("stack decrement wrong");

  property p_dex_three;
    (state == alu_slice_pkg::S_FETCH && RDATA == alu_slice_pkg::OP_DEC_XY) |=> state == alu_slice_pkg::S_INH
      ##1 (state == alu_slice_pkg::S_DUMMY && ADDR == alu_slice_pkg::IDLE_ADDR)
      ##1 (state == alu_slice_pkg::S_FETCH || state == alu_slice_pkg::S_HALT);
  endproperty
  a_dex_three: assert property (p_dex_three) else $error("index decrement cycles wrong");

  property p_idx_flags;
    idx_exec |=> ((pre ? index_y : index_x) == $past(d16_in) - 16'h0001 &&
                  condition_code_reg[alu_slice_pkg::CC_Z] == ((pre ? index_y : index_x) == 16'h0000) &&
                  condition_code_reg[7:3] == $past(condition_code_reg[7:3]) && condition_code_reg[1:0] == $past(condition_code_reg[1:0]));
  endproperty
  a_idx_flags: assert property (p_idx_flags) else $error("index decrement flags wrong");

  property p_xor;
    (ccr_we && alu_op == alu_slice_pkg::ALU_XOR) |=> (!condition_code_reg[alu_slice_pkg::CC_V] &&
      condition_code_reg[alu_slice_pkg::CC_C] == $past(condition_code_reg[alu_slice_pkg::CC_C]) && condition_code_reg[alu_slice_pkg::CC_H] == $past(condition_code_reg[alu_slice_pkg::CC_H]));
  endproperty
  a_xor: assert property (p_xor) else $error("xor flags wrong");
endmodule // alu_slice_top

// *** sim/mem_model.sv ***
// Program and data memory answering the slice's bus in the same cycle
`timescale 1ns/1ps
module mem_model (
  input wire logic clk, // Clock
  input wire logic [15:0] addr, // Bus address
  input wire logic rw, // High read, low write
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata // Read data
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  // Device owns the data lines while writing, so show no stale byte
  assign rdata = rw ? mem[addr] : ~wdata;
  always @(posedge clk) begin
    if (!rw) mem[addr] <= wdata;
  end
endmodule // mem_model

// *** sim/alu_slice_top_tb_top.sv ***
// Self-checking bench for the decrement, xor and decimal-adjust slice
`timescale 1ns/1ps
module alu_slice_top_tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr;
  logic rw;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] d;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 clock = ~clock;
  alu_slice_top alu_slice_top_inst (.CLOCK(clock), .RSTN(rstn), .ADDR(addr), .RW(rw), .WDATA(wdata),
    .RDATA(rdata), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));
  mem_model mem_model_inst (.clk(clock), .addr(addr), .rw(rw), .wdata(wdata), .rdata(rdata));
  // ===========================================
  // Tasks
  task give_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  // Code at 0100, an illegal 00 behind it halts the core
  task run(input logic [31:0] code);
    logic [15:0] s;
    for (int n = 0; n < 4; n++) mem_model_inst.mem[16'h0100 + n] = code[31 - 8 * n -: 8];
    mem_model_inst.mem[16'h0104] = 8'h00;
    wr(4'h6, 16'h0100);
    wr(4'h8, 16'h0002);
    wr(4'h7, 16'h0001);
    for (int n = 0; n < 20; n++) begin
      rd(4'h8, s);
      if (s[0] === 1'b0) break;
    end
  endtask
  // Register index f stands for the data byte at 0040
  task tc(input logic [31:0] code, input logic [3:0] r, input logic [15:0] v, ci, ev, eo);
    logic [15:0] x;
    if (r == 4'hf) mem_model_inst.mem[16'h0040] = v[7:0];
    else wr(r, v);
    wr(4'h5, ci);
    run(code);
    if (r == 4'hf) x = {8'h00, mem_model_inst.mem[16'h0040]};
    else rd(r, x);
    chk(x, ev);
    rd(4'h5, x);
    chk(x, eo);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ===========================================
  // Tests
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rd(4'h0, d);
    chk(d, 16'h0000);
    wr(4'h9, 16'hffff);
    rd(4'h9, d);
    chk(d, 16'h0000);
    tc(32'h19000000, 4'h0, 16'h00bb, 16'h0000, 16'h0021, 16'h0001);
    tc(32'h19000000, 4'h0, 16'h000a, 16'h0000, 16'h0010, 16'h0000);
    tc(32'h19000000, 4'h0, 16'h0025, 16'h0001, 16'h0085, 16'h0009);
    tc(32'h19000000, 4'h0, 16'h00a5, 16'h0000, 16'h0005, 16'h0001);
    tc(32'h19000000, 4'h0, 16'h0012, 16'h0020, 16'h0018, 16'h0020);
    tc(32'h4a000000, 4'h0, 16'h0080, 16'h0001, 16'h007f, 16'h0003);
    tc(32'h5a000000, 4'h1, 16'h0001, 16'h000a, 16'h0000, 16'h0004);
    tc(32'h7a004000, 4'hf, 16'h0000, 16'h0000, 16'h00ff, 16'h0008);
    wr(4'h2, 16'h0030);
    wr(4'h3, 16'h0030);
    tc(32'h6a100000, 4'hf, 16'h0081, 16'h0001, 16'h0080, 16'h0009);
    tc(32'h186a1000, 4'hf, 16'h0080, 16'h0000, 16'h007f, 16'h0002);
    tc(32'h09000000, 4'h2, 16'h0001, 16'h000b, 16'h0000, 16'h000f);
    tc(32'h18090000, 4'h3, 16'h0000, 16'h0004, 16'hffff, 16'h0000);
    tc(32'h34000000, 4'h4, 16'h0000, 16'h002f, 16'hffff, 16'h002f);
    chk(addr, 16'hffff);
    tc(32'h88f00000, 4'h0, 16'h000f, 16'h0023, 16'h00ff, 16'h0029);
    tc(32'hd8400000, 4'h1, 16'h007f, 16'h000a, 16'h0000, 16'h0004);
    tc(32'hb8004000, 4'h0, 16'h0070, 16'h0000, 16'h000f, 16'h0000);
    wr(4'h2, 16'h0030);
    wr(4'h3, 16'h0030);
    tc(32'ha8100000, 4'h0, 16'h0080, 16'h0002, 16'h00ff, 16'h0008);
    tc(32'h18e81000, 4'h1, 16'h00f0, 16'h0023, 16'h008f, 16'h0029);
    give_verdict();
  end
endmodule // alu_slice_top_tb_top
